// ==== src/fid_top.sv ====
`timescale 1ns/10ps
module fid_top
	import fid_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	typedef struct packed {
		fid_st_e     st;
		logic [13:0] insn;
		logic [31:0] ctrl;
		logic        aw_full;
		logic [7:0]  aw_addr;
		logic        w_full;
		logic [31:0] w_data;
		logic [3:0]  w_strb;
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic [3:0]  flags;
		logic        two_last;
		logic        src_pins;
		logic        psc_clr;
		logic        sleeping;
		logic        psc_sticky;
		logic        illegal;
		logic [15:0] n_cyc;
		logic [15:0] n_psc;
	} fid_top_s;

	fid_top_s r_reg;
	fid_top_s r_next;
	logic     last;
	logic     skip;
	logic     is_port;
	logic     do_wr;
	logic     psc_hit;
	logic [31:0] wmerge;
	logic [31:0] rd_val;
	logic [1:0]  rd_resp;

	fid_dec_if dif ();

	assign dif.word = r_reg.insn;

	fid_decode u_dec (
		.d (dif)
	);

	fid_phase #(
		.N (OSC_PER_CYC)
	) u_phase (
		.aclk    (aclk),
		.aresetn (aresetn),
		.run     (r_reg.st != ST_IDLE),
		.last    (last)
	);

	// ------------------------------------------------------------
	// Byte lane merge
	// ------------------------------------------------------------
	function automatic logic [31:0] merge(
		input logic [31:0] old,
		input logic [31:0] nw,
		input logic [3:0]  strb
	);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i])
				res[i*8 +: 8] = nw[i*8 +: 8];
		end
		return res;
	endfunction : merge

	// ------------------------------------------------------------
	// Execution conditions
	// ------------------------------------------------------------
	always_comb begin
		skip = 1'b0;
		unique case (dif.op)
			OP_DOWN_COUNT_SKIP, OP_UP_COUNT_SKIP:
				skip = r_reg.ctrl[CB_ZERO];
			OP_TEST_SKIP_CLEAR: skip = !r_reg.ctrl[CB_BIT];
			OP_TEST_SKIP_SET:   skip = r_reg.ctrl[CB_BIT];
			default:            skip = 1'b0;
		endcase
	end

	assign is_port = dif.faddr == F_PORT_A || dif.faddr == F_PORT_B;
	assign psc_hit = dif.wr_file && dif.faddr == F_TIMER0
		&& r_reg.ctrl[CB_PSA];

	// ------------------------------------------------------------
	// Read data mux
	// ------------------------------------------------------------
	always_comb begin
		rd_val  = 32'h0000_0000;
		rd_resp = RESP_OK;
		unique case (s_axi_araddr)
			A_INSN: rd_val = {18'h0_0000, r_reg.insn};
			A_CTRL: rd_val = r_reg.ctrl;
			A_STAT: rd_val = {19'h0_0000, r_reg.illegal, r_reg.flags,
				r_reg.psc_sticky, r_reg.sleeping, r_reg.psc_clr,
				r_reg.src_pins, r_reg.two_last, r_reg.st,
				r_reg.st != ST_IDLE};
			A_DEC:  rd_val = {10'h000, dif.op, 1'b0, dif.may_skip,
				dif.two_cyc, dif.wr_file, dif.dest, dif.target};
			A_CNT:  rd_val = {r_reg.n_psc, r_reg.n_cyc};
			default: rd_resp = RESP_DEC;
		endcase
	end

	assign do_wr = r_reg.aw_full && r_reg.w_full && !r_reg.bvalid;
	assign wmerge = merge(32'h0000_0000, r_reg.w_data, r_reg.w_strb);

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		r_next = r_reg;

		// Instruction cycle sequencing
		if (last) begin
			r_next.n_cyc = r_reg.n_cyc + 16'h0001;
			if (r_reg.st == ST_EXEC) begin
				r_next.flags    = dif.flags;
				r_next.illegal  = dif.op == OP_ILLEGAL;
				r_next.src_pins = dif.rmw && is_port;
				r_next.psc_clr  = psc_hit;
				r_next.sleeping = dif.op == OP_STANDBY;
				if (psc_hit)
					r_next.n_psc = r_reg.n_psc + 16'h0001;
				if (dif.two_cyc || skip) begin
					r_next.st       = ST_FLUSH;
					r_next.two_last = 1'b1;
				end else begin
					r_next.st       = ST_IDLE;
					r_next.two_last = 1'b0;
				end
			end else begin
				r_next.st = ST_IDLE;
			end
		end

		// Write address and data capture
		if (s_axi_awvalid && r_reg.awready) begin
			r_next.aw_full = 1'b1;
			r_next.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && r_reg.wready) begin
			r_next.w_full = 1'b1;
			r_next.w_data = s_axi_wdata;
			r_next.w_strb = s_axi_wstrb;
		end

		if (do_wr) begin
			r_next.bvalid  = 1'b1;
			r_next.bresp   = RESP_OK;
			r_next.aw_full = 1'b0;
			r_next.w_full  = 1'b0;
			unique case (r_reg.aw_addr)
				A_INSN: begin
					if (r_reg.st != ST_IDLE) begin
						r_next.bresp = RESP_SLV;
					end else begin
						r_next.insn = wmerge[13:0];
						r_next.st   = ST_EXEC;
					end
				end
				A_CTRL: r_next.ctrl = merge(r_reg.ctrl, r_reg.w_data,
					r_reg.w_strb);
				A_STAT: begin
					if (wmerge[SB_PSC_STICKY])
						r_next.psc_sticky = 1'b0;
				end
				A_DEC, A_CNT: r_next.bresp = RESP_OK;
				default: r_next.bresp = RESP_DEC;
			endcase
		end else if (r_reg.bvalid && s_axi_bready) begin
			r_next.bvalid = 1'b0;
		end

		if (last && r_reg.st == ST_EXEC && psc_hit)
			r_next.psc_sticky = 1'b1;

		// Read channel
		if (s_axi_arvalid && r_reg.arready) begin
			r_next.rvalid = 1'b1;
			r_next.rdata  = rd_val;
			r_next.rresp  = rd_resp;
		end else if (r_reg.rvalid && s_axi_rready) begin
			r_next.rvalid = 1'b0;
		end

		r_next.awready = !r_next.aw_full;
		r_next.wready  = !r_next.w_full;
		r_next.arready = !r_next.rvalid;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			r_reg      <= '0;
			r_reg.st   <= ST_IDLE;
			r_reg.ctrl <= CTRL_RST;
		end else begin
			r_reg <= r_next;
		end
	end

	assign s_axi_awready = r_reg.awready;
	assign s_axi_wready  = r_reg.wready;
	assign s_axi_bvalid  = r_reg.bvalid;
	assign s_axi_bresp   = r_reg.bresp;
	assign s_axi_arready = r_reg.arready;
	assign s_axi_rvalid  = r_reg.rvalid;
	assign s_axi_rdata   = r_reg.rdata;
	assign s_axi_rresp   = r_reg.rresp;

endmodule : fid_top

// ==== include/fid_pkg.sv ====
// How it works
// - Plain instructions take one cycle; taken skips and jumps take two, second idle.
// - One instruction cycle is four consecutive clock periods.
// - Byte ops: file address bits 6-0, destination bit 7 (0 acc, 1 file).
// - Bit ops: bit index bits 9-7, file address bits 6-0.
// - Literal and control ops take eight-bit literal from the low byte.
// - Call (bit 11 = 0) and jump (bit 11 = 1) use 11-bit target, two cycles.
// - Byte opcode field bits 13-8 selects the fourteen arithmetic and logic ops.
// - Count-and-skip ops skip on zero result, two cycles when the skip is taken, flags untouched.
// - Rotates through carry update only the carry flag.
// - Bit ops: clear, set, test-skip-if-clear, test-skip-if-set.
// - Literal or, xor and and update only the zero flag.
// - Literal subtract and add update C, half carry, Z; literal load none.
// - Return with literal loads the accumulator and takes two cycles.
// - Standby word takes one cycle and updates expiry and sleep flags.
// - Port read-modify-write takes its operand from the pins.
// - Writing timer zero count clears the prescaler when assigned to it.
package fid_pkg;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int OSC_PER_CYC = 4;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [7:0] A_INSN = 8'h00;
	localparam logic [7:0] A_CTRL = 8'h04;
	localparam logic [7:0] A_STAT = 8'h08;
	localparam logic [7:0] A_DEC  = 8'h0c;
	localparam logic [7:0] A_CNT  = 8'h10;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam int CB_PSA  = 0;
	localparam int CB_ZERO = 1;
	localparam int CB_BIT  = 2;
	localparam int SB_PSC_STICKY = 7;
	localparam logic [1:0] RESP_OK  = 2'h0;
	localparam logic [1:0] RESP_SLV = 2'h2;
	localparam logic [1:0] RESP_DEC = 2'h3;

	// ------------------------------------------------------------
	// File addresses and flags
	// ------------------------------------------------------------
	localparam logic [6:0] F_TIMER0 = 7'h01;
	localparam logic [6:0] F_PORT_A = 7'h05;
	localparam logic [6:0] F_PORT_B = 7'h06;
	localparam int FL_C      = 0;
	localparam int FL_HALF   = 1;
	localparam int FL_Z      = 2;
	localparam int FL_EXPIRY = 3;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_EXEC  = 2'b01,
		ST_FLUSH = 2'b10
	} fid_st_e;

	typedef enum logic [5:0] {
		OP_ADD_ACC_TO_FILE = 6'b000000, OP_AND_ACC_WITH_FILE = 6'b000001,
		OP_SUB_ACC_FROM_FILE = 6'b000010, OP_OR_ACC_WITH_FILE = 6'b000011,
		OP_XOR_ACC_WITH_FILE = 6'b000100, OP_INVERT_FILE = 6'b000101,
		OP_FILE_MINUS_ONE = 6'b000110, OP_FILE_PLUS_ONE = 6'b000111,
		OP_COPY_FILE = 6'b001000, OP_NIBBLE_EXCHANGE = 6'b001001,
		OP_DOWN_COUNT_SKIP = 6'b001010, OP_UP_COUNT_SKIP = 6'b001011,
		OP_ROTATE_LEFT = 6'b001100, OP_ROTATE_RIGHT = 6'b001101,
		OP_STORE_ACC = 6'b001110, OP_ZERO_FILE = 6'b001111,
		OP_ZERO_ACC = 6'b010000, OP_IDLE_INSN = 6'b010001,
		OP_BIT_CLEAR = 6'b010010, OP_BIT_SET = 6'b010011,
		OP_TEST_SKIP_CLEAR = 6'b010100, OP_TEST_SKIP_SET = 6'b010101,
		OP_OR_LITERAL = 6'b010110, OP_XOR_LITERAL = 6'b010111,
		OP_AND_LITERAL = 6'b011000, OP_LITERAL_MINUS = 6'b011001,
		OP_ADD_LITERAL = 6'b011010, OP_LOAD_LITERAL = 6'b011011,
		OP_RETURN_LITERAL = 6'b011100, OP_CALL_SUB = 6'b011101,
		OP_JUMP_ABSOLUTE = 6'b011110, OP_SUB_RETURN = 6'b011111,
		OP_INT_RETURN = 6'b100000, OP_STANDBY = 6'b100001,
		OP_WATCHDOG_KICK = 6'b100010, OP_ILLEGAL = 6'b111111
	} fid_op_e;

endpackage : fid_pkg

// ==== include/fid_dec_if.sv ====
`timescale 1ns/10ps
interface fid_dec_if;
	import fid_pkg::*;
	logic [13:0] word;
	fid_op_e     op;
	logic        dest;
	logic [6:0]  faddr;
	logic [2:0]  bidx;
	logic [7:0]  lit;
	logic [10:0] target;
	logic [3:0]  flags;
	logic        wr_file;
	logic        rmw;
	logic        two_cyc;
	logic        may_skip;

	modport prod (
		input  word,
		output op, dest, faddr, bidx, lit, target, flags,
		output wr_file, rmw, two_cyc, may_skip
	);
	modport cons (
		output word,
		input  op, dest, faddr, bidx, lit, target, flags,
		input  wr_file, rmw, two_cyc, may_skip
	);
endinterface : fid_dec_if

// ==== src/fid_decode.sv ====
`timescale 1ns/10ps
module fid_decode
	import fid_pkg::*;
(
	fid_dec_if.prod d
);
	logic [13:0] w;
	logic        byte_op;

	assign w = d.word;
	assign d.dest   = w[7];
	assign d.faddr  = w[6:0];
	assign d.bidx   = w[9:7];
	assign d.lit    = w[7:0];
	assign d.target = w[10:0];

	always_comb begin
		d.op = OP_ILLEGAL;
		unique case (w[13:12])
			2'b00: begin
				unique case (w[11:8])
					4'b0111: d.op = OP_ADD_ACC_TO_FILE;
					4'b0101: d.op = OP_AND_ACC_WITH_FILE;
					4'b0010: d.op = OP_SUB_ACC_FROM_FILE;
					4'b0100: d.op = OP_OR_ACC_WITH_FILE;
					4'b0110: d.op = OP_XOR_ACC_WITH_FILE;
					4'b1001: d.op = OP_INVERT_FILE;
					4'b0011: d.op = OP_FILE_MINUS_ONE;
					4'b1010: d.op = OP_FILE_PLUS_ONE;
					4'b1000: d.op = OP_COPY_FILE;
					4'b1110: d.op = OP_NIBBLE_EXCHANGE;
					4'b1011: d.op = OP_DOWN_COUNT_SKIP;
					4'b1111: d.op = OP_UP_COUNT_SKIP;
					4'b1101: d.op = OP_ROTATE_LEFT;
					4'b1100: d.op = OP_ROTATE_RIGHT;
					4'b0001: begin
						if (w[7])
							d.op = OP_ZERO_FILE;
						else if (w[6:0] == 7'h03)
							d.op = OP_ZERO_ACC;
					end
					4'b0000: begin
						if (w[7])
							d.op = OP_STORE_ACC;
						else if (w[6:0] == 7'h08)
							d.op = OP_SUB_RETURN;
						else if (w[6:0] == 7'h09)
							d.op = OP_INT_RETURN;
						else if (w[6:0] == 7'h63)
							d.op = OP_STANDBY;
						else if (w[6:0] == 7'h64)
							d.op = OP_WATCHDOG_KICK;
						else if (w[4:0] == 5'h00)
							d.op = OP_IDLE_INSN;
					end
				endcase
			end
			2'b01: begin
				unique case (w[11:10])
					2'b00: d.op = OP_BIT_CLEAR;
					2'b01: d.op = OP_BIT_SET;
					2'b10: d.op = OP_TEST_SKIP_CLEAR;
					2'b11: d.op = OP_TEST_SKIP_SET;
				endcase
			end
			2'b10: d.op = w[11] ? OP_JUMP_ABSOLUTE : OP_CALL_SUB;
			2'b11: begin
				unique casez (w[11:8])
					4'b1000: d.op = OP_OR_LITERAL;
					4'b1010: d.op = OP_XOR_LITERAL;
					4'b1001: d.op = OP_AND_LITERAL;
					4'b110?: d.op = OP_LITERAL_MINUS;
					4'b111?: d.op = OP_ADD_LITERAL;
					4'b00??: d.op = OP_LOAD_LITERAL;
					4'b01??: d.op = OP_RETURN_LITERAL;
					default: d.op = OP_ILLEGAL;
				endcase
			end
		endcase
	end

	always_comb begin
		d.flags    = 4'h0;
		d.two_cyc  = 1'b0;
		d.may_skip = 1'b0;
		byte_op    = 1'b0;
		d.wr_file  = 1'b0;
		unique case (d.op)
			OP_ADD_ACC_TO_FILE, OP_SUB_ACC_FROM_FILE: begin
				d.flags = 4'h7;
				byte_op = 1'b1;
			end
			OP_AND_ACC_WITH_FILE, OP_OR_ACC_WITH_FILE, OP_XOR_ACC_WITH_FILE,
			OP_INVERT_FILE, OP_FILE_MINUS_ONE, OP_FILE_PLUS_ONE,
			OP_COPY_FILE: begin
				d.flags[FL_Z] = 1'b1;
				byte_op       = 1'b1;
			end
			OP_NIBBLE_EXCHANGE: byte_op = 1'b1;
			OP_DOWN_COUNT_SKIP, OP_UP_COUNT_SKIP: begin
				byte_op    = 1'b1;
				d.may_skip = 1'b1;
			end
			OP_ROTATE_LEFT, OP_ROTATE_RIGHT: begin
				d.flags[FL_C] = 1'b1;
				byte_op       = 1'b1;
			end
			OP_STORE_ACC: d.wr_file = 1'b1;
			OP_ZERO_FILE: begin
				d.flags[FL_Z] = 1'b1;
				d.wr_file     = 1'b1;
			end
			OP_ZERO_ACC: d.flags[FL_Z] = 1'b1;
			OP_BIT_CLEAR, OP_BIT_SET: d.wr_file = 1'b1;
			OP_TEST_SKIP_CLEAR, OP_TEST_SKIP_SET: d.may_skip = 1'b1;
			OP_OR_LITERAL, OP_XOR_LITERAL, OP_AND_LITERAL:
				d.flags[FL_Z] = 1'b1;
			OP_LITERAL_MINUS, OP_ADD_LITERAL: d.flags = 4'h7;
			OP_RETURN_LITERAL, OP_CALL_SUB, OP_JUMP_ABSOLUTE, OP_SUB_RETURN,
			OP_INT_RETURN: d.two_cyc = 1'b1;
			OP_STANDBY, OP_WATCHDOG_KICK: d.flags[FL_EXPIRY] = 1'b1;
			default: d.flags = 4'h0;
		endcase
		if (byte_op)
			d.wr_file = w[7];
	end

	assign d.rmw = d.wr_file && d.op != OP_STORE_ACC
		&& d.op != OP_ZERO_FILE;

endmodule : fid_decode

// ==== src/fid_phase.sv ====
`timescale 1ns/10ps
module fid_phase
	import fid_pkg::*;
#(
	parameter int N = OSC_PER_CYC
) (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic run,
	output logic      last
);
	typedef struct packed {
		logic [$clog2(N)-1:0] cnt;
	} fid_ph_s;

	fid_ph_s st_reg;
	fid_ph_s st_next;

	always_comb begin
		st_next = st_reg;
		if (!run || last)
			st_next.cnt = '0;
		else
			st_next.cnt = st_reg.cnt + 1'b1;
	end

	assign last = run && (int'(st_reg.cnt) == N - 1);

	always_ff @(posedge aclk) begin
		if (!aresetn)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

endmodule : fid_phase

// ==== dv/fid_top_chk.sv ====
`timescale 1ns/10ps
module fid_top_chk
	import fid_pkg::*;
(
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready
);
	// ----------------------------------------
	// Register bus timing
	// ----------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_b_after_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
			|-> ##2 s_axi_bvalid;
	endproperty
	a_b_after_take: assert property (p_b_after_take)
		else $error("no write response after take");
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold)
		else $error("write response dropped early");
	property p_b_release;
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
	endproperty
	a_b_release: assert property (p_b_release)
		else $error("write response not released");
	property p_r_after_take;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_r_after_take: assert property (p_r_after_take)
		else $error("no read data one cycle after take");
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_r_hold: assert property (p_r_hold)
		else $error("read data dropped early");
	property p_r_release;
		s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid ##1 s_axi_arready;
	endproperty
	a_r_release: assert property (p_r_release)
		else $error("read channel not reopened");
	property p_ar_excl;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	a_ar_excl: assert property (p_ar_excl)
		else $error("read address open while data pending");
	property p_r_quiet;
		!s_axi_rvalid && !(s_axi_arvalid && s_axi_arready) |=> !s_axi_rvalid;
	endproperty
	a_r_quiet: assert property (p_r_quiet)
		else $error("read data without request");
	c_write: cover property (s_axi_bvalid && s_axi_bready);
	c_read: cover property (s_axi_rvalid && s_axi_rready);
	c_slverr: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLV);
endmodule : fid_top_chk

bind fid_top fid_top_chk u_chk (.aclk, .aresetn, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
	.s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rvalid, .s_axi_rready);

// ==== dv/fid_prog_mem.sv ====
`timescale 1ns/10ps
module fid_prog_mem (
	input  wire logic [5:0]  idx,
	output logic      [13:0] base,
	output logic      [13:0] mask,
	output logic      [3:0]  flags,
	output logic      [2:0]  kind
);
	// Row: fixed bits, operand bits, flags touched, timing kind
	typedef struct packed {
		logic [13:0] b;
		logic [13:0] m;
		logic [3:0]  f;
		logic [2:0]  k;
	} fid_row_s;
	localparam fid_row_s ROM [36] = '{
		'{14'h0700, 14'h00ff, 4'h7, 3'h0}, '{14'h0500, 14'h00ff, 4'h4, 3'h0},
		'{14'h0200, 14'h00ff, 4'h7, 3'h0}, '{14'h0400, 14'h00ff, 4'h4, 3'h0},
		'{14'h0600, 14'h00ff, 4'h4, 3'h0}, '{14'h0900, 14'h00ff, 4'h4, 3'h0},
		'{14'h0300, 14'h00ff, 4'h4, 3'h0}, '{14'h0a00, 14'h00ff, 4'h4, 3'h0},
		'{14'h0800, 14'h00ff, 4'h4, 3'h0}, '{14'h0e00, 14'h00ff, 4'h0, 3'h0},
		'{14'h0b00, 14'h00ff, 4'h0, 3'h2}, '{14'h0f00, 14'h00ff, 4'h0, 3'h2},
		'{14'h0d00, 14'h00ff, 4'h1, 3'h0}, '{14'h0c00, 14'h00ff, 4'h1, 3'h0},
		'{14'h0080, 14'h007f, 4'h0, 3'h0}, '{14'h0180, 14'h007f, 4'h4, 3'h0},
		'{14'h0103, 14'h0000, 4'h4, 3'h0}, '{14'h0000, 14'h0060, 4'h0, 3'h0},
		'{14'h1000, 14'h03ff, 4'h0, 3'h0}, '{14'h1400, 14'h03ff, 4'h0, 3'h0},
		'{14'h1800, 14'h03ff, 4'h0, 3'h3}, '{14'h1c00, 14'h03ff, 4'h0, 3'h4},
		'{14'h3800, 14'h00ff, 4'h4, 3'h0}, '{14'h3a00, 14'h00ff, 4'h4, 3'h0},
		'{14'h3900, 14'h00ff, 4'h4, 3'h0}, '{14'h3c00, 14'h01ff, 4'h7, 3'h0},
		'{14'h3e00, 14'h01ff, 4'h7, 3'h0}, '{14'h3000, 14'h03ff, 4'h0, 3'h0},
		'{14'h3400, 14'h03ff, 4'h0, 3'h1}, '{14'h2000, 14'h07ff, 4'h0, 3'h1},
		'{14'h2800, 14'h07ff, 4'h0, 3'h1}, '{14'h0008, 14'h0000, 4'h0, 3'h1},
		'{14'h0009, 14'h0000, 4'h0, 3'h1}, '{14'h0063, 14'h0000, 4'h8, 3'h0},
		'{14'h0064, 14'h0000, 4'h8, 3'h0}, '{14'h0001, 14'h0000, 4'h0, 3'h0}};
	assign {base, mask, flags, kind} = (idx < 6'h24) ? ROM[idx] : ROM[35];
endmodule : fid_prog_mem

// ==== dv/fourteen_bit_insn_decoder_test.sv ====
`timescale 1ns/10ps
module fourteen_bit_insn_decoder_test;
	import fid_pkg::*;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00;
	logic [7:0]  s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic        s_axi_awvalid = 1'b0;
	logic        s_axi_wvalid = 1'b0;
	logic        s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0;
	logic        s_axi_rready = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic        s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic [5:0]  idx = 6'h00;
	logic [13:0] pbase, pmask;
	logic [3:0]  pflags;
	logic [2:0]  pkind;
	int          failures = 0;
	int          check_count = 0;

	fid_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	fid_prog_mem u_mem (.idx(idx), .base(pbase), .mask(pmask),
		.flags(pflags), .kind(pkind));

	always #25 aclk = ~aclk;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1 && n < 100);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		if (n >= 100) failures++;
	endtask : axw

	task axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1 && n < 100);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		if (n >= 100) failures++;
	endtask : axr

	task run(input logic [13:0] w, input logic [2:0] c,
		output logic [31:0] st, output logic [31:0] dec,
		output logic [15:0] dn);
		logic [1:0]  r;
		logic [31:0] c0, c1;
		int          n;
		axw(A_CTRL, {29'h0000_0000, c}, r);
		axr(A_CNT, c0, r);
		axw(A_INSN, {18'h0_0000, w}, r);
		chk(32'(r), 32'(RESP_OK));
		n = 0;
		st = 32'h0000_0001;
		while (st[0] !== 1'b0 && n < 40) begin
			axr(A_STAT, st, r);
			n++;
		end
		axr(A_DEC, dec, r);
		axr(A_CNT, c1, r);
		dn = c1[15:0] - c0[15:0];
	endtask : run

	function automatic logic exp_two(input logic [2:0] k, input logic [2:0] c);
		return k == 3'h1 || (k == 3'h2 && c[1]) || (k == 3'h3 && !c[2])
			|| (k == 3'h4 && c[2]);
	endfunction : exp_two

	function automatic logic [10:0] exp_fm(input logic [5:0] i);
		if (i <= 6'd15) return 11'h07f;
		if (i >= 6'd18 && i <= 6'd21) return 11'h3ff;
		if (i >= 6'd22 && i <= 6'd28) return 11'h0ff;
		if (i == 6'd29 || i == 6'd30) return 11'h7ff;
		return 11'h000;
	endfunction : exp_fm

	task final_report;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : final_report

	initial begin
		#(50ns * 40000);
		failures++;
		final_report;
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		logic [31:0] st, dec, d;
		logic [15:0] dn;
		logic [13:0] w;
		logic [2:0]  c;
		logic [1:0]  r;
		logic        two;
		void'($urandom(32'h56cc_c6bd));
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		axr(A_CTRL, d, r);
		chk(d, CTRL_RST);
		axr(8'h14, d, r);
		chk(32'(r), 32'(RESP_DEC));
		axw(8'h14, 32'h0000_0000, r);
		chk(32'(r), 32'(RESP_DEC));
		for (int k = 0; k < 90; k++) begin
			idx = (k < 36) ? 6'(k) : 6'($urandom_range(35, 0));
			c = 3'($urandom);
			#1;
			w = pbase | (14'($urandom) & pmask);
			run(w, c, st, dec, dn);
			two = exp_two(pkind, c);
			chk(32'(dec[21:16]), (idx == 6'd35) ? 32'(OP_ILLEGAL) : 32'(idx));
			chk(32'(dn), two ? 32'h0000_0002 : 32'h0000_0001);
			chk(32'(st[3]), 32'(two));
			chk(32'(st[11:8]), 32'(pflags));
			chk(32'(st[6]), 32'(idx == 6'd33));
			chk(32'(st[12]), 32'(idx == 6'd35));
			chk(32'(dec[10:0] & exp_fm(idx)), 32'(w[10:0] & exp_fm(idx)));
			if (idx < 6'd14) chk(32'(dec[11]), 32'(w[7]));
		end
		axw(A_INSN, 32'h0000_2800, r);
		axw(A_INSN, 32'h0000_0000, r);
		chk(32'(r), 32'(RESP_SLV));
		run(14'h0180 | 14'(F_TIMER0), 3'h1, st, dec, dn);
		chk(32'(st[7:5]), 32'h0000_0005);
		run(14'h0800 | 14'(F_TIMER0), 3'h1, st, dec, dn);
		chk(32'(st[5]), 32'h0000_0000);
		axw(A_STAT, 32'h0000_0080, r);
		axr(A_STAT, st, r);
		chk(32'(st[7]), 32'h0000_0000);
		run(14'h0880 | 14'(F_PORT_B), 3'h0, st, dec, dn);
		chk(32'(st[4]), 32'h0000_0001);
		run(14'h08a0, 3'h0, st, dec, dn);
		chk(32'(st[4]), 32'h0000_0000);
		final_report;
	end
endmodule : fourteen_bit_insn_decoder_test
